// *** core/mmd_decode.sv ***
// memory map decoder: cpu access routing, reset load of nonvolatile bytes, vectors
// assumes mem_rdata is valid the cycle after mem_rd; all inputs on clk
`timescale 1ns/10ps
module mmd_decode (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cpu_req,
    input wire logic [mmd_pkg::ADDR_W-1:0] cpu_addr,
    input wire logic cpu_direct,
    input wire logic cpu_we,
    input wire logic [mmd_pkg::DATA_W-1:0] cpu_wdata,
    input wire mmd_pkg::mmd_bitop_t cpu_bitop,
    input wire logic [2:0] cpu_bitnum,
    output logic cpu_ack,
    output logic [mmd_pkg::DATA_W-1:0] cpu_rdata,
    output logic cpu_ready,
    input wire logic vec_req,
    input wire logic [4:0] vec_slot,
    output logic vec_ack,
    output logic [mmd_pkg::ADDR_W-1:0] vec_data,
    output logic [mmd_pkg::ADDR_W-1:0] mem_addr,
    output mmd_pkg::mmd_tgt_t mem_tgt,
    output logic mem_rd,
    output logic mem_wr,
    output logic [mmd_pkg::DATA_W-1:0] mem_wdata,
    input wire logic [mmd_pkg::DATA_W-1:0] mem_rdata,
    output logic [mmd_pkg::DATA_W-1:0] flash_protection_byte,
    output logic [mmd_pkg::DATA_W-1:0] flash_option_byte,
    output logic [mmd_pkg::KEY_BYTES*mmd_pkg::DATA_W-1:0] backdoor_key
);
    import mmd_pkg::*;

    typedef enum {S_LOAD, S_IDLE, S_ISSUED, S_DATA} mmd_state_t;
    typedef enum {K_LOAD, K_CPU, K_RMW, K_VHI, K_VLO} mmd_kind_t;

    mmd_state_t state_reg;
    mmd_kind_t kind_reg;
    logic [3:0] load_idx_reg;
    logic [15:0] acc_addr_reg;
    mmd_bitop_t bitop_reg;
    logic [2:0] bitnum_reg;
    logic [7:0] vec_hi_reg;
    logic [15:0] full_addr;
    mmd_tgt_t full_tgt;
    logic [15:0] vec_addr;
    logic [7:0] rd_masked;
    logic [7:0] bit_one;

    function automatic logic [15:0] load_addr(input logic [3:0] idx);
        if (idx == LOAD_PROT_IDX)
            return NV_PROT_ADDR;
        if (idx == LOAD_LAST)
            return NV_OPT_ADDR;
        return NV_KEY_ADDR + {12'h000, idx};
    endfunction

    always_comb begin
        full_addr = cpu_direct ? {8'h00, cpu_addr[7:0]} : cpu_addr;
        full_tgt = mmd_target(full_addr);
        vec_addr = VEC_BASE + {10'h000, vec_slot, 1'b0};
        rd_masked = mem_rdata & ~mmd_zero_mask(acc_addr_reg);
        bit_one = 8'h01 << bitnum_reg;
    end

    // sequencing of loads, accesses and vector fetches
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_reg <= S_LOAD;
            kind_reg <= K_LOAD;
            load_idx_reg <= 4'h0;
            acc_addr_reg <= 16'h0000;
            bitop_reg <= BIT_NONE;
            bitnum_reg <= 3'h0;
            vec_hi_reg <= 8'h00;
        end else begin
            case (state_reg)
                S_LOAD: begin
                    kind_reg <= K_LOAD;
                    acc_addr_reg <= load_addr(load_idx_reg);
                    state_reg <= S_ISSUED;
                end
                S_IDLE: begin
                    if (vec_req) begin
                        kind_reg <= K_VHI;
                        acc_addr_reg <= vec_addr;
                        state_reg <= S_ISSUED;
                    end else if (cpu_req) begin
                        acc_addr_reg <= full_addr;
                        bitop_reg <= cpu_bitop;
                        bitnum_reg <= cpu_bitnum;
                        if (mmd_reserved(full_addr)) begin
                            state_reg <= S_IDLE;
                        end else if (cpu_bitop != BIT_NONE && full_tgt == TGT_DP) begin
                            kind_reg <= K_RMW;
                            state_reg <= S_ISSUED;
                        end else if (!cpu_we) begin
                            kind_reg <= K_CPU;
                            state_reg <= S_ISSUED;
                        end
                    end
                end
                S_ISSUED: state_reg <= S_DATA;
                S_DATA: begin
                    case (kind_reg)
                        K_LOAD: begin
                            load_idx_reg <= load_idx_reg + 4'h1;
                            state_reg <= (load_idx_reg == LOAD_LAST) ? S_IDLE : S_LOAD;
                        end
                        K_VHI: begin
                            vec_hi_reg <= mem_rdata;
                            acc_addr_reg <= acc_addr_reg + 16'h0001;
                            kind_reg <= K_VLO;
                            state_reg <= S_ISSUED;
                        end
                        default: state_reg <= S_IDLE;
                    endcase
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // memory bus strobes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            mem_addr <= 16'h0000;
            mem_tgt <= TGT_NONE;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
        end else begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            if (state_reg == S_LOAD) begin
                mem_addr <= load_addr(load_idx_reg);
                mem_tgt <= TGT_NVR;
                mem_rd <= 1'b1;
            end else if (state_reg == S_IDLE && vec_req) begin
                mem_addr <= vec_addr;
                mem_tgt <= TGT_FLASH;
                mem_rd <= 1'b1;
            end else if (state_reg == S_IDLE && cpu_req && !mmd_reserved(full_addr)) begin
                mem_addr <= full_addr;
                mem_tgt <= full_tgt;
                mem_wdata <= cpu_wdata;
                if (cpu_bitop != BIT_NONE && full_tgt == TGT_DP)
                    mem_rd <= 1'b1;
                else if (!cpu_we)
                    mem_rd <= 1'b1;
                else
                    mem_wr <= full_tgt != TGT_NVR && full_tgt != TGT_FLASH;
            end else if (state_reg == S_IDLE && cpu_req) begin
                mem_tgt <= TGT_NONE;
            end else if (state_reg == S_DATA && kind_reg == K_VHI) begin
                mem_addr <= acc_addr_reg + 16'h0001;
                mem_rd <= 1'b1;
            end else if (state_reg == S_DATA && kind_reg == K_RMW) begin
                mem_wr <= 1'b1;
                mem_wdata <= (bitop_reg == BIT_SET) ? (rd_masked | bit_one)
                                                    : (rd_masked & ~bit_one);
            end
        end
    end

    // cpu answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cpu_ack <= 1'b0;
            cpu_rdata <= 8'h00;
        end else begin
            cpu_ack <= 1'b0;
            if (state_reg == S_IDLE && !vec_req && cpu_req) begin
                if (mmd_reserved(full_addr)) begin
                    cpu_ack <= 1'b1;
                    cpu_rdata <= RSVD_READ;
                end else if (cpu_we && !(cpu_bitop != BIT_NONE && full_tgt == TGT_DP)) begin
                    cpu_ack <= 1'b1;
                end
            end else if (state_reg == S_DATA && (kind_reg == K_CPU || kind_reg == K_RMW)) begin
                cpu_ack <= 1'b1;
                cpu_rdata <= rd_masked;
            end
        end
    end

    // vector answer
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            vec_ack <= 1'b0;
            vec_data <= 16'h0000;
        end else begin
            vec_ack <= state_reg == S_DATA && kind_reg == K_VLO;
            if (state_reg == S_DATA && kind_reg == K_VLO)
                vec_data <= {vec_hi_reg, mem_rdata};
        end
    end

    // working copies of nonvolatile bytes
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flash_protection_byte <= PROT_RESET;
            flash_option_byte <= OPT_RESET;
            backdoor_key <= '0;
            cpu_ready <= 1'b0;
        end else if (state_reg == S_DATA && kind_reg == K_LOAD) begin
            if (load_idx_reg == LOAD_PROT_IDX)
                flash_protection_byte <= mem_rdata;
            else if (load_idx_reg == LOAD_LAST) begin
                flash_option_byte <= mem_rdata;
                cpu_ready <= 1'b1;
            end else
                backdoor_key[load_idx_reg[2:0]*DATA_W +: DATA_W] <= mem_rdata;
        end
    end
endmodule

// *** core/mmd_pkg.sv ***
// constants, target types and bit-mask tables for the memory map decoder
// assumes a byte-wide cpu core and one shared memory bus with 1-cycle read latency
// What this block does
// - direct page 0x0000-0x007f goes to direct-page group
// - 0x1800-0x185f goes to high-page group
// - 0xffb0-0xffbf decodes as nonvolatile flash registers
// - reset copies protection and option bytes
// - nonvolatile area holds eight-byte backdoor key
// - vectors fetched high then low, fixed pairs
// - unassigned vector pairs are plain flash
// - direct page spans first 128 byte addresses
// - direct addressing forms address with zero high byte
// - bit set/clear as byte read-modify-write on the direct page
// - unused-zero bits always read zero
package mmd_pkg;
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    localparam logic [15:0] DP_LAST = 16'h007f;
    localparam logic [15:0] HP_FIRST = 16'h1800;
    localparam logic [15:0] HP_LAST = 16'h185f;
    localparam logic [15:0] NV_FIRST = 16'hffb0;
    localparam logic [15:0] NV_LAST = 16'hffbf;
    localparam logic [15:0] FLASH_FIRST = 16'he000;
    localparam logic [15:0] NV_KEY_ADDR = 16'hffb0;
    localparam logic [15:0] NV_PROT_ADDR = 16'hffbd;
    localparam logic [15:0] NV_OPT_ADDR = 16'hffbf;
    localparam int KEY_BYTES = 8;
    localparam logic [3:0] LOAD_LAST = 4'h9;
    localparam logic [3:0] LOAD_PROT_IDX = 4'h8;
    localparam logic [15:0] VEC_BASE = 16'hffc0;
    localparam logic [4:0] VEC_SLOT_RESET = 5'h1f;
    localparam logic [4:0] VEC_SLOT_SWI = 5'h1e;
    localparam logic [4:0] VEC_SLOT_LVD = 5'h1c;
    localparam logic [7:0] RSVD_READ = 8'h00;
    localparam logic [7:0] PROT_RESET = 8'hff;
    localparam logic [7:0] OPT_RESET = 8'hff;

    typedef enum logic [2:0] {
        TGT_NONE, TGT_DP, TGT_HP, TGT_NVR, TGT_FLASH, TGT_OTHER
    } mmd_tgt_t;
    typedef enum logic [1:0] {BIT_NONE, BIT_SET, BIT_CLR} mmd_bitop_t;

    function automatic mmd_tgt_t mmd_target(input logic [15:0] a);
        if (a <= DP_LAST) return TGT_DP;
        if (a >= HP_FIRST && a <= HP_LAST) return TGT_HP;
        if (a >= NV_FIRST && a <= NV_LAST) return TGT_NVR;
        if (a >= FLASH_FIRST) return TGT_FLASH;
        return TGT_OTHER;
    endfunction

    // holes inside the register groups
    function automatic logic mmd_reserved(input logic [15:0] a);
        logic [7:0] l;
        l = a[7:0];
        if (a <= DP_LAST)
            return (l >= 8'h06 && l <= 8'h0d) || l == 8'h0f ||
                   (l >= 8'h19 && l <= 8'h1b) || (l >= 8'h2b && l <= 8'h37) ||
                   (l >= 8'h40 && l <= 8'h47) || (l >= 8'h4c && l <= 8'h4f) ||
                   l == 8'h54 || l == 8'h56 || l == 8'h57 || l == 8'h5e ||
                   l == 8'h5f || l == 8'h6b || l >= 8'h6f;
        if (a >= HP_FIRST && a <= HP_LAST)
            return l == 8'h04 || l == 8'h05 || l == 8'h08 ||
                   (l >= 8'h0b && l <= 8'h0f);
        return 1'b0;
    endfunction

    // bits that always read zero
    function automatic logic [7:0] mmd_zero_mask(input logic [15:0] a);
        if (a <= DP_LAST) begin
            case (a[7:0])
                8'h00, 8'h01, 8'h1d: return 8'hc0;
                8'h04, 8'h05, 8'h18: return 8'hf0;
                8'h12, 8'h14: return 8'hfc;
                8'h1c: return 8'h0f;
                8'h25, 8'h28, 8'h65, 8'h68, 8'h5a: return 8'h03;
                8'h38, 8'h3d: return 8'h20;
                8'h4b: return 8'he0;
                8'h51: return 8'he4;
                8'h52: return 8'h88;
                8'h53: return 8'h4f;
                8'h58: return 8'h01;
                8'h5b: return 8'h08;
                8'h5d: return 8'h1c;
                default: return 8'h00;
            endcase
        end
        if (a >= HP_FIRST && a <= HP_LAST) begin
            case (a[7:0])
                8'h00: return 8'h05;
                8'h01: return 8'hfe;
                8'h02: return 8'h1b;
                8'h03: return 8'h2c;
                8'h09: return 8'h02;
                8'h0a: return 8'hc0;
                default: return 8'h00;
            endcase
        end
        return 8'h00;
    endfunction
endpackage

// *** verif/memory_map_decode_tb_top.sv ***
// self-checking bench for the memory map decoder with a far-side memory model
// assumes package, decoder, model and bound checker compiled first
`timescale 1ns/10ps
module memory_map_decode_tb_top;
    import mmd_pkg::*;
    logic clk = 0, reset_n = 0, cpu_req = 0, cpu_direct = 0, cpu_we = 0, vec_req = 0;
    logic [15:0] cpu_addr = 0;
    logic [7:0] cpu_wdata = 0;
    mmd_bitop_t cpu_bitop = BIT_NONE;
    logic [2:0] cpu_bitnum = 0;
    logic [4:0] vec_slot = 0;
    logic cpu_ack, cpu_ready, vec_ack, mem_rd, mem_wr, wr_s;
    logic [7:0] cpu_rdata, mem_wdata, mem_rdata, flash_protection_byte, flash_option_byte;
    logic [7:0] rd_v, wd_s;
    logic [15:0] vec_data, mem_addr, vd;
    logic [63:0] backdoor_key;
    mmd_tgt_t mem_tgt, tgt_s;
    int failures = 0, n_compared = 0;
    always #4 clk = ~clk;
    mmd_decode dut (.clk, .reset_n, .cpu_req, .cpu_addr, .cpu_direct, .cpu_we, .cpu_wdata,
        .cpu_bitop, .cpu_bitnum, .cpu_ack, .cpu_rdata, .cpu_ready, .vec_req, .vec_slot, .vec_ack,
        .vec_data, .mem_addr, .mem_tgt, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata,
        .flash_protection_byte, .flash_option_byte, .backdoor_key);
    mmd_mem_model mem (.clk, .mem_addr, .mem_tgt, .mem_rd, .mem_wr, .mem_wdata, .mem_rdata);
    function automatic logic [7:0] pat(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    task chk(string n, logic [15:0] e, logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task end_sim;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task do_reset;
        @(posedge clk);
        #1 reset_n = 0;
        repeat (5) @(posedge clk);
        chk("rst_ready", 16'h0, cpu_ready);
        chk("rst_prot", PROT_RESET, flash_protection_byte);
        chk("rst_opt", OPT_RESET, flash_option_byte);
        #1 reset_n = 1;
        for (int i = 0; i < 60 && cpu_ready !== 1'b1; i++) @(posedge clk);
        #1 chk("ready", 16'h1, cpu_ready);
        chk("prot", pat(NV_PROT_ADDR), flash_protection_byte);
        chk("opt", pat(NV_OPT_ADDR), flash_option_byte);
        for (int i = 0; i < 8; i++) begin
            chk("key", pat(NV_KEY_ADDR + 16'(i)), backdoor_key[8*i +: 8]);
        end
    endtask
    task acc(logic [15:0] a, logic d, logic w, logic [7:0] wd, mmd_bitop_t op, logic [2:0] b);
        @(posedge clk);
        #1 cpu_req = 1;
        cpu_addr = a;
        cpu_direct = d;
        cpu_we = w;
        cpu_wdata = wd;
        cpu_bitop = op;
        cpu_bitnum = b;
        tgt_s = TGT_NONE;
        wr_s = 1'b0;
        wd_s = 8'h00;
        @(posedge clk);
        #1 cpu_req = 0;
        for (int i = 0; i < 10; i++) begin
            if (mem_rd || mem_wr) tgt_s = mem_tgt;
            if (mem_wr) {wr_s, wd_s} = {1'b1, mem_wdata};
            if (cpu_ack === 1'b1) break;
            @(posedge clk);
            #1;
        end
        chk("ack", 16'h1, cpu_ack);
        rd_v = cpu_rdata;
    endtask
    task automatic t_map;
        logic [15:0] a [11] = '{16'h0000, 16'h1804, 16'h0040, 16'h007f, 16'h0080, 16'h1800,
            16'h185f, 16'h1860, 16'hffb0, 16'hffbf, 16'hffc0};
        mmd_tgt_t t [11] = '{TGT_DP, TGT_DP, TGT_NONE, TGT_NONE, TGT_OTHER, TGT_HP, TGT_HP,
            TGT_OTHER, TGT_NVR, TGT_NVR, TGT_FLASH};
        logic [7:0] e [11] = '{8'h25, 8'h01, 8'h00, 8'h00, 8'hbc, 8'h20, 8'h7b, 8'h44, 8'h73,
            8'h7c, 8'h03};
        for (int i = 0; i < 11; i++) begin
            acc(a[i], i == 1, 1'b0, 8'h00, BIT_NONE, 3'h0);
            chk("tgt", t[i], tgt_s);
            chk("rdata", e[i], rd_v);
        end
        // only named and zero bits are judged, dash bits are left out
        acc(16'h0000, 1'b0, 1'b0, 8'h00, BIT_NONE, 3'h0);
        chk("named_bits", 8'h05, rd_v & 8'hcf);
    endtask
    task t_write;
        acc(16'h0002, 1'b0, 1'b1, 8'h3c, BIT_NONE, 3'h0);
        chk("wdata", 8'h3c, wd_s);
        acc(16'h0002, 1'b0, 1'b0, 8'h00, BIT_NONE, 3'h0);
        chk("rback", 8'h3c, rd_v);
        acc(NV_PROT_ADDR, 1'b0, 1'b1, 8'h00, BIT_NONE, 3'h0);
        chk("nv_wr", 16'h0, wr_s);
        acc(16'h0040, 1'b0, 1'b1, 8'h55, BIT_NONE, 3'h0);
        chk("rsvd_wr", 16'h0, wr_s);
    endtask
    task t_bits;
        acc(16'h0002, 1'b0, 1'b0, 8'h00, BIT_SET, 3'h7);
        chk("set", 8'hbc, wd_s);
        acc(16'h9902, 1'b1, 1'b0, 8'h00, BIT_CLR, 3'h2);
        chk("clr", 8'hb8, wd_s);
        chk("clr_old", 8'hbc, rd_v);
    endtask
    task automatic t_vec;
        logic [4:0] s [4] = '{5'h1f, 5'h1e, 5'h1c, 5'h00};
        logic [15:0] va;
        for (int i = 0; i < 4; i++) begin
            va = 16'hffc0 + {10'h000, s[i], 1'b0};
            @(posedge clk);
            #1 {vec_req, vec_slot} = {1'b1, s[i]};
            @(posedge clk);
            #1 vec_req = 0;
            for (int j = 0; j < 10; j++) begin
                if (vec_ack === 1'b1) break;
                @(posedge clk);
                #1;
            end
            chk("vec_ack", 16'h1, vec_ack);
            vd = vec_data;
            chk("vec", {pat(va), pat(va + 16'h0001)}, vd);
        end
    endtask
    initial begin
        do_reset;
        t_map;
        t_write;
        t_bits;
        t_vec;
        do_reset;
        end_sim;
    end
    initial begin
        #20000;
        failures++;
        end_sim;
    end
endmodule

// *** verif/mmd_decode_monitor.sv ***
// concurrent checks on the memory map decoder ports
// assumes binding onto every mmd_decode instance, single clock
`timescale 1ns/10ps
module mmd_decode_monitor (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic cpu_req,
    input wire logic [15:0] cpu_addr,
    input wire logic cpu_direct,
    input wire logic cpu_we,
    input wire logic cpu_ack,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_ready,
    input wire logic vec_req,
    input wire logic [4:0] vec_slot,
    input wire logic vec_ack,
    input wire logic [15:0] vec_data,
    input wire logic [15:0] mem_addr,
    input wire mmd_pkg::mmd_tgt_t mem_tgt,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_rdata
);
    import mmd_pkg::*;
    logic go;
    logic [7:0] wait_reg;
    assign go = cpu_req && cpu_ready && !vec_req;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    // cycles spent loading after reset
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wait_reg <= 8'h00;
        end else if (!cpu_ready && wait_reg != 8'hff) begin
            wait_reg <= wait_reg + 8'h01;
        end
    end
    chk_dp_route: assert property (
        (mem_rd || mem_wr) && mem_addr <= DP_LAST |-> mem_tgt == TGT_DP)
        else $error("direct page misrouted");
    chk_hp_route: assert property (
        (mem_rd || mem_wr) && mem_addr >= HP_FIRST && mem_addr <= HP_LAST
        |-> mem_tgt == TGT_HP)
        else $error("high page misrouted");
    chk_nv_route: assert property (
        mem_rd && mem_addr >= NV_FIRST && mem_addr <= NV_LAST |-> mem_tgt == TGT_NVR)
        else $error("nonvolatile area misrouted");
    chk_nv_nowrite: assert property (
        mem_wr |-> mem_tgt != TGT_NVR && mem_tgt != TGT_FLASH)
        else $error("write strobe into flash");
    chk_direct_page: assert property (
        go && cpu_direct && !cpu_we |=> !mem_rd || mem_addr[15:8] == 8'h00)
        else $error("direct address high byte not zero");
    chk_vec_order: assert property (
        vec_req && cpu_ready |=> mem_rd && mem_addr == {10'h3ff, $past(vec_slot), 1'b0}
        ##2 mem_rd && mem_addr[0] ##2 vec_ack)
        else $error("vector fetch order wrong");
    chk_vec_pair: assert property (
        vec_ack |-> vec_data == {$past(mem_rdata, 3), $past(mem_rdata)})
        else $error("vector bytes misplaced");
    chk_unused_zero: assert property (
        cpu_ack && $past(mem_rd, 2) && $past(mem_addr, 2) == 16'h0004
        |-> cpu_rdata[7:4] == 4'h0)
        else $error("unused bits not zero");
    chk_reserved_rd: assert property (
        go && !cpu_we && cpu_addr >= 16'h0040 && cpu_addr <= 16'h0047
        |=> cpu_ack && !mem_rd && cpu_rdata == RSVD_READ)
        else $error("reserved read not refused");
    chk_load_time: assert property (wait_reg <= 8'h28)
        else $error("reset load too long");
endmodule
bind mmd_decode mmd_decode_monitor mon (.clk, .reset_n, .cpu_req, .cpu_addr, .cpu_direct,
    .cpu_we, .cpu_ack, .cpu_rdata, .cpu_ready, .vec_req, .vec_slot, .vec_ack, .vec_data,
    .mem_addr, .mem_tgt, .mem_rd, .mem_wr, .mem_rdata);

// *** verif/mmd_mem_model.sv ***
// far-side memory and register model answering the decoder bus
// assumes read data is due the cycle after a read strobe
`timescale 1ns/10ps
module mmd_mem_model (
    input wire logic clk,
    input wire logic [15:0] mem_addr,
    input wire mmd_pkg::mmd_tgt_t mem_tgt,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    import mmd_pkg::*;
    logic [7:0] dp_reg [128];
    logic [15:0] addr_reg;
    logic rd_reg = 1'b0;
    logic [7:0] junk_reg = 8'h5a;
    initial begin
        for (int i = 0; i < 128; i++) dp_reg[i] = 8'(i) ^ 8'ha5;
    end
    always @(posedge clk) begin
        rd_reg <= mem_rd;
        addr_reg <= mem_addr;
        junk_reg <= ~junk_reg;
        if (mem_wr && mem_tgt == TGT_DP) dp_reg[mem_addr[6:0]] <= mem_wdata;
    end
    // bus toggles when no read answer is due
    assign mem_rdata = !rd_reg ? junk_reg : addr_reg <= DP_LAST ? dp_reg[addr_reg[6:0]]
        : addr_reg[7:0] ^ addr_reg[15:8] ^ 8'h3c;
endmodule
